/* bench/mdio_host_model.sv */
// Management bus host that clocks out frames and reads answers.
`timescale 1ns/100ps
module mdio_host_model (
  // Pins
  input wire logic clk,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  output logic mdc_pin,
  output logic mdio_in
);
  logic drv = 1'h0;
  logic bit_v = 1'h1;
  // The data line has a pull-up, so a released line reads high.
  assign mdio_in = drv ? bit_v : (mdio_oe_n ? 1'h1 : mdio_out);
  initial mdc_pin = 1'h0;
  task automatic clk_bit(input logic b, output logic s);
    @(posedge clk);
    #1 mdc_pin = 1'h0;
    bit_v = b;
    repeat (6) @(posedge clk);
    #1 mdc_pin = 1'h1;
    s = mdio_in;
    repeat (5) @(posedge clk);
  endtask
  task automatic frame(input logic st2, input logic [1:0] op, input logic [4:0] pa, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [45:0] hdr;
    logic [17:0] tail;
    logic [17:0] got;
    logic s;
    hdr = {32'hFFFFFFFF, 1'h0, st2, op, pa, 5'h03};
    tail = {2'h2, wd};
    drv = 1'h1;
    for (int i = 45; i >= 0; i--) clk_bit(hdr[i], s);
    #1 drv = !op[1];
    for (int i = 17; i >= 0; i--)
    begin
      clk_bit(tail[i], s);
      got[i] = s;
    end
    #1 drv = 1'h0;
    mdc_pin = 1'h0;
    rd = got[15:0];
  endtask
endmodule // mdio_host_model

/* bench/mdio_port_strap_decode_bench.sv */
// Self-checking bench for the strap decoder.
`timescale 1ns/100ps
module mdio_port_strap_decode_bench;
  import mdio_strap_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic mdio_clause_select = 1'h0;
  logic mode_select_pin = 1'h0;
  logic pin_power_down_low = 1'h1;
  logic pattern_check_enable = 1'h0;
  logic pattern_error = 1'h0;
  logic register_power_down = 1'h0;
  logic [4:0] port_address_pins = 5'h15;
  logic mdc_pin, mdio_in, mdio_out, mdio_oe_n, pattern_pass_flag, pattern_pass_oe_n, clause22_active;
  logic general_purpose_in;
  op_mode_t operating_mode;
  logic [1:0] frame_op;
  logic frame_read_req, frame_write_strobe;
  logic [4:0] frame_dev_addr;
  int n_rd = 0;
  int n_wr = 0;
  logic [15:0] frame_wdata, rd;
  int mismatches = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  mdio_port_strap_decode u_mdio_port_strap_decode (.*, .frame_rdata(16'hA5C3));
  mdio_host_model u_mdio_host_model (.*);
  // The frame pulses last one cycle, so they are counted on every edge instead of being polled.
  always @(posedge clk)
  begin
    if (frame_read_req === 1'h1)
      n_rd++;
    if (frame_write_strobe === 1'h1)
      n_wr++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic t_frames();
    u_mdio_host_model.frame(1'h0, 2'h1, 5'h14, 16'h1234, rd);
    cyc(2);
    chk("wdata", frame_wdata, 16'h1234);
    chk("dev addr", 16'(frame_dev_addr), 16'h3);
    chk("write pulses", 16'(n_wr), 16'h1);
    chk("gp input", 16'(general_purpose_in), 16'h1);
    u_mdio_host_model.frame(1'h0, 2'h3, 5'h14, 16'h0, rd);
    chk("read data", rd, 16'hA5C3);
    chk("read pulses", 16'(n_rd), 16'h1);
    // Foreign frames: bit zero set, then upper bits wrong.
    u_mdio_host_model.frame(1'h0, 2'h1, 5'h15, 16'h5555, rd);
    u_mdio_host_model.frame(1'h0, 2'h3, 5'h04, 16'h0, rd);
    cyc(2);
    chk("foreign wdata", frame_wdata, 16'h1234);
    chk("foreign op", 16'(frame_op), 16'h3);
    chk("foreign read", rd, 16'hFFFF);
    chk("foreign read pulses", 16'(n_rd), 16'h1);
    chk("foreign write pulses", 16'(n_wr), 16'h1);
    $display("frames done");
  endtask
  task automatic t_pass();
    pattern_check_enable = 1'h1;
    cyc(4);
    chk("pass clean", 16'(pattern_pass_flag), 16'h1);
    pattern_error = 1'h1;
    cyc(2);
    chk("pass error", 16'(pattern_pass_flag), 16'h0);
    pattern_error = 1'h0;
    register_power_down = 1'h1;
    cyc(2);
    chk("reg pd", 16'(pattern_pass_oe_n), 16'h1);
    register_power_down = 1'h0;
    pin_power_down_low = 1'h0;
    cyc(4);
    chk("pin pd", 16'({pattern_pass_oe_n, mdio_oe_n}), 16'h3);
    pin_power_down_low = 1'h1;
    pattern_check_enable = 1'h0;
    cyc(4);
    chk("pass idle", 16'({pattern_pass_oe_n, pattern_pass_flag}), 16'h1);
    port_address_pins = 5'h14;
    cyc(4);
    chk("gp input low", 16'(general_purpose_in), 16'h0);
    $display("pass pin done");
  endtask
  task automatic t_straps();
    for (int i = 0; i < 4; i++)
    begin
      mdio_clause_select = i[1];
      mode_select_pin = i[0];
      reset = 1'h1;
      cyc(20);
      reset = 1'h0;
      cyc(1);
      chk("clause", 16'(clause22_active), 16'(i[1]));
      chk("mode", 16'(operating_mode), i[1] ? 16'h2 : 16'(i[0]));
    end
    u_mdio_host_model.frame(1'h1, 2'h1, 5'h14, 16'h0F0F, rd);
    chk("c22 wdata", frame_wdata, 16'h0F0F);
    u_mdio_host_model.frame(1'h1, 2'h2, 5'h14, 16'h0, rd);
    chk("c22 read", rd, 16'hA5C3);
    u_mdio_host_model.frame(1'h0, 2'h2, 5'h14, 16'h0, rd);
    chk("c45 start refused", rd, 16'hFFFF);
    $display("straps done");
  endtask
  initial
  begin
    cyc(3);
    chk("reset pass", 16'({pattern_pass_oe_n, pattern_pass_flag, mdio_oe_n}), 16'h3);
    cyc(17);
    reset = 1'h0;
    t_frames();
    t_pass();
    t_straps();
    print_verdict();
  end
  initial
  begin
    #400000;
    mismatches++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule // mdio_port_strap_decode_bench

/* bench/mdio_strap_properties.sv */
// Port checker for the strap decoder and the pass flag pin.
`timescale 1ns/100ps
module mdio_strap_properties
  import mdio_strap_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic mdio_oe_n,
  input wire logic mdio_clause_select,
  input wire logic mode_select_pin,
  input wire logic [4:0] port_address_pins,
  input wire logic pin_power_down_low,
  input wire logic pattern_check_enable,
  input wire logic pattern_error,
  input wire logic register_power_down,
  input wire logic pattern_pass_flag,
  input wire logic pattern_pass_oe_n,
  input wire op_mode_t operating_mode,
  input wire logic clause22_active,
  input wire logic general_purpose_in,
  input wire logic frame_read_req,
  input wire logic frame_write_strobe,
  input wire logic [15:0] frame_wdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Pins pass two synchronisers, so three stable cycles are needed first.
  sequence s_en3;
    pattern_check_enable [*3];
  endsequence
  sequence s_pd3;
    !pin_power_down_low [*3];
  endsequence
  AST_RST_PASS: assert property (disable iff (1'b0) reset && $past(reset) |-> pattern_pass_flag && !pattern_pass_oe_n)
    else $error("pass pin not high in reset");
  AST_PIN_PD: assert property (s_pd3 |=> pattern_pass_oe_n && mdio_oe_n)
    else $error("pins driven in power down");
  AST_REG_PD: assert property (register_power_down |=> pattern_pass_oe_n)
    else $error("pass pin driven in power down");
  AST_PASS_ERR: assert property (s_en3 |=> pattern_pass_flag != $past(pattern_error))
    else $error("pass flag wrong");
  AST_PASS_OFF: assert property (!pattern_check_enable [*3] |=> pattern_pass_flag)
    else $error("pass flag low while idle");
  AST_GPIN: assert property ($stable(port_address_pins[0]) [*3] |-> general_purpose_in == port_address_pins[0])
    else $error("general input wrong");
  AST_CLAUSE: assert property ($fell(reset) |-> clause22_active == mdio_clause_select)
    else $error("clause wrong");
  AST_MODE: assert property ($fell(reset) |->
    operating_mode == (mdio_clause_select ? MODE_C22 : op_mode_t'({1'h0, mode_select_pin})))
    else $error("mode wrong");
  AST_READ: assert property (frame_read_req |-> ##[1:30] !mdio_oe_n)
    else $error("read not answered");
  AST_WDATA: assert property ($changed(frame_wdata) |-> frame_write_strobe)
    else $error("write data moved");
endmodule // mdio_strap_properties

bind mdio_port_strap_decode mdio_strap_properties u_mdio_strap_properties (.*);

/* design/mdio_port_strap_decode.sv */
// Strap handling, management frame decoder and pattern pass pin control.
`timescale 1ns/100ps
module mdio_port_strap_decode
  import mdio_strap_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Management pins
  input wire logic mdc_pin,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  // Strap and control pins
  input wire logic mdio_clause_select,
  input wire logic mode_select_pin,
  input wire logic [4:0] port_address_pins,
  input wire logic pin_power_down_low,
  input wire logic pattern_check_enable,
  // Internal controls from the same clock
  input wire logic pattern_error,
  input wire logic register_power_down,
  // Pass flag pin
  output logic pattern_pass_flag,
  output logic pattern_pass_oe_n,
  // Strap results
  output op_mode_t operating_mode,
  output logic clause22_active,
  output logic general_purpose_in,
  // Frame side towards the register map
  output logic frame_read_req,
  output logic frame_write_strobe,
  output logic [1:0] frame_op,
  output logic [4:0] frame_dev_addr,
  output logic [15:0] frame_wdata,
  input wire logic [15:0] frame_rdata
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  logic mdc_prev_ff;

  always_ff @(posedge clk)
  begin
    meta_ff <= {mdc_pin, mdio_in, mdio_clause_select, mode_select_pin, port_address_pins, pin_power_down_low,
                pattern_check_enable};
    sync_ff <= meta_ff;
    mdc_prev_ff <= sync_ff[10];
  end

  wire mdc_s = sync_ff[10];
  wire mdio_s = sync_ff[9];
  wire st_s = sync_ff[8];
  wire mode_s = sync_ff[7];
  wire [4:0] prtad_s = sync_ff[6:2];
  wire pd_n_s = sync_ff[1];
  wire pattern_check_enable_s = sync_ff[0];
  wire mdc_rise = mdc_s & ~mdc_prev_ff;

  // ****************************************
  // Straps caught at reset
  // ****************************************
  logic clause22_ff;
  op_mode_t mode_ff;
  wire op_mode_t nxt_mode = st_s ? MODE_C22 : (mode_s ? MODE_C45_B : MODE_C45_A);

  // The strap is only taken while reset is held, so a later pin change waits for a reset.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      clause22_ff <= st_s;
      mode_ff <= nxt_mode;
    end
  end

  assign clause22_active = clause22_ff;
  assign operating_mode = mode_ff;
  assign general_purpose_in = prtad_s[0];

  // ****************************************
  // Frame decoder
  // ****************************************
  function automatic logic is_read_op(input logic c22, input logic [1:0] op);
    is_read_op = c22 ? (op == OP_C22_READ) : op[1];
  endfunction

  frame_state_t state_ff, nxt_state;
  logic [5:0] pre_cnt_ff, nxt_pre_cnt;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] shift_ff, nxt_shift;
  logic match_ff, nxt_match;
  logic read_ff, nxt_read;
  logic drive_ff, nxt_drive;
  logic out_ff, nxt_out;
  logic rd_req_ff, nxt_rd_req;
  logic strobe_ff, nxt_strobe;
  logic [1:0] op_ff;
  logic [4:0] dev_ff;
  logic [15:0] wdata_ff;

  wire [11:0] hdr_word = {shift_ff[10:0], mdio_s};
  wire start2_exp = clause22_ff ? START2_C22 : START2_C45;
  wire hdr_match = (hdr_word[9:6] == prtad_s[4:1]) && !hdr_word[5];
  wire hdr_read = is_read_op(clause22_ff, hdr_word[11:10]);
  wire hdr_done = mdc_rise && (state_ff == S_HDR) && (cnt_ff == HDR_LAST);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_pre_cnt = pre_cnt_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_match = match_ff;
    nxt_read = read_ff;
    nxt_drive = drive_ff;
    nxt_out = out_ff;
    nxt_rd_req = 1'b0;
    nxt_strobe = 1'b0;
    if (mdc_rise)
    begin
      unique case (state_ff)
        S_PRE:
        begin
          if (mdio_s)
            nxt_pre_cnt = (pre_cnt_ff == PRE_CNT_MAX) ? pre_cnt_ff : pre_cnt_ff + 6'h01;
          else if (pre_cnt_ff == PRE_CNT_MAX)
          begin
            nxt_state = S_ST2;
            nxt_pre_cnt = 6'h00;
          end
          else
            nxt_pre_cnt = 6'h00;
        end
        S_ST2:
        begin
          nxt_cnt = 5'h00;
          nxt_state = (mdio_s == start2_exp) ? S_HDR : S_PRE;
        end
        S_HDR:
        begin
          nxt_shift = {shift_ff[14:0], mdio_s};
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff == HDR_LAST)
          begin
            nxt_state = S_TA;
            nxt_cnt = 5'h00;
            nxt_match = hdr_match;
            nxt_read = hdr_read;
            nxt_rd_req = hdr_match & hdr_read;
          end
        end
        S_TA:
        begin
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff == 5'h00)
          begin
            nxt_drive = match_ff & read_ff;
            nxt_out = 1'b0;
          end
          else if (cnt_ff == TA_LAST)
          begin
            nxt_state = S_DATA;
            nxt_cnt = 5'h00;
            nxt_out = frame_rdata[15];
            nxt_shift = {frame_rdata[14:0], 1'b0};
          end
        end
        S_DATA:
        begin
          nxt_cnt = cnt_ff + 5'h01;
          nxt_shift = drive_ff ? {shift_ff[14:0], 1'b0} : {shift_ff[14:0], mdio_s};
          nxt_out = shift_ff[15];
          if (cnt_ff == DATA_LAST)
          begin
            nxt_state = S_PRE;
            nxt_cnt = 5'h00;
            nxt_drive = 1'b0;
            nxt_out = 1'b0;
            nxt_strobe = match_ff & ~read_ff;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_ff <= S_PRE;
      pre_cnt_ff <= 6'h00;
      cnt_ff <= 5'h00;
      shift_ff <= 16'h0000;
      match_ff <= 1'b0;
      read_ff <= 1'b0;
      drive_ff <= 1'b0;
      out_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      strobe_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      pre_cnt_ff <= nxt_pre_cnt;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      match_ff <= nxt_match;
      read_ff <= nxt_read;
      drive_ff <= nxt_drive;
      out_ff <= nxt_out;
      rd_req_ff <= nxt_rd_req;
      strobe_ff <= nxt_strobe;
    end
  end

  // Header fields and write data only update for our own address.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      op_ff <= 2'h0;
      dev_ff <= 5'h00;
      wdata_ff <= 16'h0000;
    end
    else
    begin
      if (hdr_done && hdr_match)
      begin
        op_ff <= hdr_word[11:10];
        dev_ff <= hdr_word[4:0];
      end
      if (nxt_strobe)
        wdata_ff <= nxt_shift;
    end
  end

  assign frame_read_req = rd_req_ff;
  assign frame_write_strobe = strobe_ff;
  assign frame_op = op_ff;
  assign frame_dev_addr = dev_ff;
  assign frame_wdata = wdata_ff;
  assign mdio_out = out_ff;
  // The data line floats during pin power down; it keeps working under register power down.
  assign mdio_oe_n = ~(drive_ff & pd_n_s);

  // ****************************************
  // Pattern pass flag pin
  // ****************************************
  logic pass_ff;
  logic pass_oe_n_ff;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pass_ff <= PASS_RESET;
      pass_oe_n_ff <= PASS_OE_N_RESET;
    end
    else
    begin
      pass_ff <= pattern_check_enable_s ? ~pattern_error : PASS_RESET;
      pass_oe_n_ff <= ~pd_n_s | register_power_down;
    end
  end

  assign pattern_pass_flag = pass_ff;
  assign pattern_pass_oe_n = pass_oe_n_ff;

endmodule // mdio_port_strap_decode

/* design/mdio_strap_pkg.sv */
// Constants and types for the management port strap and frame decoder.
package mdio_strap_pkg;

  // ****************************************
  // Frame layout and counts
  // ****************************************
  localparam logic [5:0] PRE_CNT_MAX = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0B;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic START2_C22 = 1'h1;
  localparam logic START2_C45 = 1'h0;
  localparam logic [1:0] OP_C22_READ = 2'h2;
  localparam int SYNC_W = 11;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic PASS_RESET = 1'h1;
  localparam logic PASS_OE_N_RESET = 1'h0;
  localparam logic CLAUSE22_RESET = 1'h0;

  // ****************************************
  // Operating modes and frame states
  // ****************************************
  typedef enum logic [1:0] {
    MODE_C45_A = 2'h0,
    MODE_C45_B = 2'h1,
    MODE_C22 = 2'h2
  } op_mode_t;

  typedef enum logic [4:0] {
    S_PRE = 5'h01,
    S_ST2 = 5'h02,
    S_HDR = 5'h04,
    S_TA = 5'h08,
    S_DATA = 5'h10
  } frame_state_t;

endpackage
